// ==== logic/rtdr_pkg.sv ====
/*
 * Shared constants for the resistance readout result logic: register indices,
 * field positions, reset values and cycle counts.
 * Assumes a single 125 MHz clock and a byte-addressed register port where each
 * register takes one 32-bit word at four times its index.
 */
package rtdr_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CONTROL = 8'h00;
   localparam logic [7:0] IDX_RESULT = 8'h01;
   localparam logic [7:0] IDX_THR_HIGH = 8'h03;
   localparam logic [7:0] IDX_THR_LOW = 8'h05;
   localparam logic [7:0] IDX_FAULT = 8'h07;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h09;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTL_DETECT_BIT = 0;
   localparam int CTL_CLEAR_BIT = 1;
   localparam int FLT_HIGH_BIT = 7;
   localparam int FLT_LOW_BIT = 6;
   localparam int FLT_REF_HIGH_BIT = 5;
   localparam int FLT_REF_LOW_BIT = 4;
   localparam int FLT_SENSE_LOW_BIT = 3;
   localparam int FLT_OVUV_BIT = 2;
   localparam int IRQ_RESULT_BIT = 0;
   localparam int IRQ_THRESH_BIT = 1;
   localparam int IRQ_VOLT_BIT = 2;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [15:0] THR_HIGH_RST = 16'hFFFF;
   localparam logic [15:0] THR_LOW_RST = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h000000FF;
   localparam int DETECT_NS = 128;
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [4:0] DETECT_CYCLES = 5'(DETECT_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      DET_IDLE = 2'b01,
      DET_RUN = 2'b10
   } rtdr_det_t;

endpackage

// ==== logic/rtdr_fault_cmp.sv ====
/*
 * Threshold comparator: checks a 15-bit conversion code against the high and
 * low fault thresholds, which share the result register layout (code in 15:1).
 * Assumes the caller registers the outputs; purely combinational.
 */
`timescale 1ns/1ns
module rtdr_fault_cmp (
   input wire logic [14:0] code,
   input wire logic [15:0] thrHigh,
   input wire logic [15:0] thrLow,
   output logic hitHigh,
   output logic hitLow
);

   // ----------------------------------------------------------------
   // comparisons
   // ----------------------------------------------------------------
   // open element gives full scale, so it meets any high threshold
   assign hitHigh = (code >= thrHigh[15:1]); // R6
   assign hitLow = (code <= thrLow[15:1]); // R12

endmodule

// ==== logic/rtdr_result_logic.sv ====
/*
 * Result side of the resistance readout: result register, active-low ready
 * output, threshold and voltage fault flags, on-demand open detection and a
 * maskable interrupt, all behind a plain read/write register port.
 * Assumes conversion results arrive on this clock; the chip select and analog
 * comparator pins are asynchronous and are synchronised here.
 */
// How it works
// R1: ready output drops low as soon as a fresh result is stored.
// R2: ready output returns high once a host read of the result finishes.
// R3: result register holds the 15-bit conversion code for the host.
// R4: code is stored unscaled, ratiometric to the reference resistance.
// R5: every conversion is checked against thresholds with no extra request.
// R6: an open element gives full scale, caught by the high threshold.
// R7: high flag sets when result is at or above the high threshold.
// R8: host programs the low threshold to trip on shorted elements.
// R9: on-demand check flags when negative reference exceeds 0.85 of bias.
// R10: fault flags stay latched until the host sets the clear bit.
// R11: host waits five filter constants plus 1 ms before restarting.
// R12: low flag sets when result is at or below the low threshold.
// R13: thresholds reset to all ones (high) and all zeros (low).
// R14: writing one to the clear bit zeroes all fault flags except those set again in the same cycle.
// R15: fault bits: high 7, low 6, voltage checks 5 to 3, supply 2.
// R16: read ends when chip select rises after a result read.
// R17: a newer result overwrites and keeps the ready output low.
`timescale 1ns/1ns
module rtdr_result_logic (
   input wire logic clk,
   input wire logic reset,
   input wire logic convValid,
   input wire logic [14:0] convCode,
   input wire logic chipSelectN,
   input wire logic refNegAbovePin,
   input wire logic refNegBelowPin,
   input wire logic sensorNegBelowPin,
   input wire logic overUnderPin,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   output logic result_ready_n,
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [14:0] resultCode;
      logic resultReadyN;
      logic readCovered;
      logic [15:0] thrHigh;
      logic [15:0] thrLow;
      logic [7:0] faultStat;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      logic irqOut;
      logic [31:0] rdData;
      rtdr_pkg::rtdr_det_t detState;
      logic [4:0] detCount;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic csPrev;
   } rtdr_state_t;

   rtdr_state_t st;
   rtdr_state_t next_st;
   logic hitHigh;
   logic hitLow;
   logic wrClear;
   logic csRise;
   logic [7:0] faultSet;
   logic [2:0] irqSet;

   // byte address of a register index
   function automatic logic regHit(input logic [7:0] addr, input logic [7:0] idx);
      regHit = (addr == 8'(idx << 2));
   endfunction

   rtdr_fault_cmp u_cmp (
      .code(convCode),
      .thrHigh(st.thrHigh),
      .thrLow(st.thrLow),
      .hitHigh(hitHigh),
      .hitLow(hitLow)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      // pins pass two flops; only the second stage is read below
      next_st.sync1 = {overUnderPin, sensorNegBelowPin, refNegBelowPin,
                       refNegAbovePin, chipSelectN};
      next_st.sync2 = st.sync1;
      next_st.csPrev = st.sync2[0];
      csRise = st.sync2[0] && !st.csPrev;
      wrClear = regWr && regHit(regAddr, rtdr_pkg::IDX_CONTROL)
                && regWrData[rtdr_pkg::CTL_CLEAR_BIT];

      // fault sources for this cycle
      faultSet = 8'h00;
      if (convValid) begin
         faultSet[rtdr_pkg::FLT_HIGH_BIT] = hitHigh; // R5 R7
         faultSet[rtdr_pkg::FLT_LOW_BIT] = hitLow; // R12
      end
      faultSet[rtdr_pkg::FLT_OVUV_BIT] = st.sync2[4]; // R15
      next_st.detCount = st.detCount;
      case (st.detState)
         rtdr_pkg::DET_IDLE: begin
            next_st.detCount = 5'h00;
            if (regWr && regHit(regAddr, rtdr_pkg::IDX_CONTROL)
                && regWrData[rtdr_pkg::CTL_DETECT_BIT]) begin
               next_st.detState = rtdr_pkg::DET_RUN;
            end
         end
         rtdr_pkg::DET_RUN: begin
            next_st.detCount = st.detCount + 5'h01;
            if (st.detCount == rtdr_pkg::DETECT_CYCLES - 5'h01) begin
               // comparators are sampled once the bias has had time to settle
               faultSet[rtdr_pkg::FLT_REF_HIGH_BIT] = st.sync2[1]; // R9
               faultSet[rtdr_pkg::FLT_REF_LOW_BIT] = st.sync2[2];
               faultSet[rtdr_pkg::FLT_SENSE_LOW_BIT] = st.sync2[3];
               next_st.detState = rtdr_pkg::DET_IDLE;
            end
         end
         default: begin
            next_st.detState = rtdr_pkg::DET_IDLE;
         end
      endcase

      // latched until cleared; a fault in the clear cycle still lands
      if (wrClear) begin
         next_st.faultStat = faultSet; // R14
      end else begin
         next_st.faultStat = st.faultStat | faultSet; // R10
      end

      // result capture and ready handshake
      if (regRd && regHit(regAddr, rtdr_pkg::IDX_RESULT)) begin
         next_st.readCovered = 1'b1;
      end
      if (convValid) begin
         next_st.resultCode = convCode; // R3 R4 R17
         next_st.resultReadyN = 1'b0; // R1
         next_st.readCovered = 1'b0;
      end else if (csRise && st.readCovered) begin
         next_st.resultReadyN = 1'b1; // R2 R16
         next_st.readCovered = 1'b0;
      end

      // threshold and mask writes
      if (regWr && regHit(regAddr, rtdr_pkg::IDX_THR_HIGH)) begin
         next_st.thrHigh = regWrData[15:0];
      end
      if (regWr && regHit(regAddr, rtdr_pkg::IDX_THR_LOW)) begin
         next_st.thrLow = regWrData[15:0]; // R8
      end
      if (regWr && regHit(regAddr, rtdr_pkg::IDX_IRQ_MASK)) begin
         next_st.irqMask = regWrData[2:0];
      end

      // interrupt status: write one to clear, set wins
      irqSet = 3'h0;
      irqSet[rtdr_pkg::IRQ_RESULT_BIT] = convValid;
      irqSet[rtdr_pkg::IRQ_THRESH_BIT] = |faultSet[7:6];
      irqSet[rtdr_pkg::IRQ_VOLT_BIT] = |faultSet[5:2];
      if (regWr && regHit(regAddr, rtdr_pkg::IDX_IRQ_STAT)) begin
         next_st.irqStat = (st.irqStat & ~regWrData[2:0]) | irqSet;
      end else begin
         next_st.irqStat = st.irqStat | irqSet;
      end
      next_st.irqOut = |(st.irqStat & st.irqMask);

      // read data stands for one cycle only
      next_st.rdData = 32'h00000000;
      if (regRd) begin
         if (regHit(regAddr, rtdr_pkg::IDX_CONTROL)) begin
            next_st.rdData = {31'h00000000, st.detState == rtdr_pkg::DET_RUN};
         end else if (regHit(regAddr, rtdr_pkg::IDX_RESULT)) begin
            next_st.rdData = {16'h0000, st.resultCode, |st.faultStat};
         end else if (regHit(regAddr, rtdr_pkg::IDX_THR_HIGH)) begin
            next_st.rdData = {16'h0000, st.thrHigh};
         end else if (regHit(regAddr, rtdr_pkg::IDX_THR_LOW)) begin
            next_st.rdData = {16'h0000, st.thrLow};
         end else if (regHit(regAddr, rtdr_pkg::IDX_FAULT)) begin
            next_st.rdData = {24'h000000, st.faultStat[7:2], 2'b00}; // R15
         end else if (regHit(regAddr, rtdr_pkg::IDX_IRQ_STAT)) begin
            next_st.rdData = {29'h00000000, st.irqStat};
         end else if (regHit(regAddr, rtdr_pkg::IDX_IRQ_MASK)) begin
            next_st.rdData = {29'h00000000, st.irqMask};
         end else begin
            next_st.rdData = rtdr_pkg::UNMAPPED_READ;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
         st.resultReadyN <= 1'b1;
         st.thrHigh <= rtdr_pkg::THR_HIGH_RST; // R13
         st.thrLow <= rtdr_pkg::THR_LOW_RST; // R13
         st.detState <= rtdr_pkg::DET_IDLE;
         // synchronisers start at the idle pin levels: chip select high, comparators low,
         // so a release of reset raises no false supply fault or frame edge
         st.sync1 <= 5'h01;
         st.sync2 <= 5'h01;
         st.csPrev <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign result_ready_n = st.resultReadyN;
   assign irq = st.irqOut;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_ready_low_on_result: assert property (@(posedge clk) disable iff (reset) // R1
      convValid |=> !result_ready_n)
      else $error("ready not low after new result");

   a_ready_release_after_read: assert property (@(posedge clk) disable iff (reset) // R2
      (csRise && st.readCovered && !convValid) |=> result_ready_n)
      else $error("ready not released after result read");

   a_result_code_stored: assert property (@(posedge clk) disable iff (reset) // R3
      (regRd && regHit(regAddr, rtdr_pkg::IDX_RESULT) && !convValid)
      |=> regRdData[15:1] == $past(st.resultCode))
      else $error("result read does not return stored code");

   a_high_flag_set: assert property (@(posedge clk) disable iff (reset) // R7
      (convValid && convCode >= st.thrHigh[15:1]) |=> st.faultStat[7])
      else $error("high threshold flag missed");

   a_low_flag_set: assert property (@(posedge clk) disable iff (reset) // R12
      (convValid && convCode <= st.thrLow[15:1]) |=> st.faultStat[6])
      else $error("low threshold flag missed");

   a_fault_stays_latched: assert property (@(posedge clk) disable iff (reset) // R10
      (st.faultStat[7] && !wrClear) |=> st.faultStat[7])
      else $error("fault flag dropped without clear");

   a_clear_zeroes_faults: assert property (@(posedge clk) disable iff (reset) // R14
      (wrClear && faultSet == 8'h00) |=> st.faultStat == 8'h00)
      else $error("fault clear left flags set");

   a_detect_ref_flag: assert property (@(posedge clk) disable iff (reset) // R9
      (st.detState == rtdr_pkg::DET_RUN && st.detCount == rtdr_pkg::DETECT_CYCLES - 5'h01
       && st.sync2[1]) |=> st.faultStat[5] && st.detState == rtdr_pkg::DET_IDLE)
      else $error("on-demand open check not flagged");

   a_thresholds_at_reset: assert property (@(posedge clk) // R13
      $past(reset) |-> (st.thrHigh == 16'hFFFF && st.thrLow == 16'h0000))
      else $error("threshold reset values wrong");

   a_newer_result_kept: assert property (@(posedge clk) disable iff (reset) // R17
      (convValid && !result_ready_n) |=> (!result_ready_n && st.resultCode == $past(convCode)))
      else $error("newer result not kept while ready low");

   // threshold flags only set on a result, never on their own
   a_high_only_on_result: assert property (@(posedge clk) disable iff (reset) // R7
      (!convValid && !st.faultStat[7]) |=> !st.faultStat[7])
      else $error("high flag set without a result");

   a_low_only_on_result: assert property (@(posedge clk) disable iff (reset) // R12
      (!convValid && !st.faultStat[6]) |=> !st.faultStat[6])
      else $error("low flag set without a result");

   a_open_full_scale: assert property (@(posedge clk) disable iff (reset) // R6
      (convValid && convCode == 15'h7FFF) |=> st.faultStat[7])
      else $error("full scale code not flagged high");

   // low and reference flags survive until the clear write; supply and low comparator flags set
   a_low_flag_latched: assert property (@(posedge clk) disable iff (reset) // R10
      (st.faultStat[6] && !wrClear) |=> st.faultStat[6])
      else $error("low flag dropped without clear");

   a_ref_flag_latched: assert property (@(posedge clk) disable iff (reset) // R10
      (st.faultStat[5] && !wrClear) |=> st.faultStat[5])
      else $error("reference flag dropped without clear");

   a_supply_flag_set: assert property (@(posedge clk) disable iff (reset) // R15
      st.sync2[4] |=> st.faultStat[2])
      else $error("supply fault not flagged");

   a_detect_low_flags: assert property (@(posedge clk) disable iff (reset) // R15
      (st.detState == rtdr_pkg::DET_RUN && st.detCount == rtdr_pkg::DETECT_CYCLES - 5'h01
       && st.sync2[2] && st.sync2[3]) |=> (st.faultStat[4] && st.faultStat[3]))
      else $error("low comparator flags not set");

   // register views of the flags
   a_fault_read_layout: assert property (@(posedge clk) disable iff (reset) // R15
      (regRd && regHit(regAddr, rtdr_pkg::IDX_FAULT))
      |=> regRdData[7:0] == {$past(st.faultStat[7:2]), 2'b00})
      else $error("fault register layout wrong");

   a_result_fault_bit: assert property (@(posedge clk) disable iff (reset) // R3
      (regRd && regHit(regAddr, rtdr_pkg::IDX_RESULT))
      |=> regRdData[0] == ($past(st.faultStat) != 8'h00))
      else $error("result fault summary bit wrong");

   a_ready_held_unread: assert property (@(posedge clk) disable iff (reset) // R16
      (!result_ready_n && !st.readCovered) |=> !result_ready_n)
      else $error("ready released without a result read");

endmodule

// ==== sim/rtdr_host_model.sv ====
/*
 * Host-side model: the serial master's chip-select pin around result reads.
 * Assumes the bench calls select and deselect from its own sequence.
 */
`timescale 1ns/1ns
module rtdr_host_model (
   input wire logic clk,
   output logic chipSelectN
);
   // ----------------------------------------------------------------
   // chip select, idle high between frames
   // ----------------------------------------------------------------
   initial chipSelectN = 1'b1;
   // the design synchronises the pin, so it may change right at the edge
   task automatic select();
      @(posedge clk);
      chipSelectN <= 1'b0;
   endtask
   // frame ends after the result read, which releases ready
   task automatic deselect();
      @(posedge clk);
      chipSelectN <= 1'b1;
   endtask
endmodule

// ==== sim/testbench.sv ====
/*
 * Self-checking bench for the result, ready, fault and interrupt logic.
 * Assumes the register map and timings of rtdr_pkg; clk at 125 MHz.
 */
`timescale 1ns/1ns
module testbench;
   logic clk, reset, convValid, regWr, regRd, refNegAbovePin, overUnderPin;
   logic chipSelectN, readyN, irq, refNegBelowPin, sensorNegBelowPin;
   logic [14:0] convCode;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, rd;
   int bad_count, n_tests, cyc;
   localparam logic [7:0] A_CTL = 8'h00, A_RES = 8'h04, A_THH = 8'h0C, A_THL = 8'h14;
   localparam logic [7:0] A_FLT = 8'h1C, A_IST = 8'h20, A_IMK = 8'h24;
   localparam logic [31:0] F_HI = 32'h80, F_LO = 32'h40, F_REF = 32'h20, F_OV = 32'h04;

   rtdr_result_logic rtdr_result_logic_i (.clk(clk), .reset(reset), .convValid(convValid),
      .convCode(convCode), .chipSelectN(chipSelectN), .refNegAbovePin(refNegAbovePin),
      .refNegBelowPin(refNegBelowPin), .sensorNegBelowPin(sensorNegBelowPin),
      .overUnderPin(overUnderPin),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .result_ready_n(readyN), .irq(irq));
   rtdr_host_model rtdr_host_model_i (.clk(clk), .chipSelectN(chipSelectN));

   // ----------------------------------------------------------------
   // clock, timeout and verdict
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rd = regRdData;
   endtask
   task automatic conv(input logic [14:0] c);
      @(posedge clk);
      convValid <= 1'b1;
      convCode <= c;
      @(posedge clk);
      convValid <= 1'b0;
      #1;
   endtask
   // bounded wait: chip select passes a two-flop synchroniser first
   task automatic wait_ready_high();
      for (int i = 0; i < 12 && readyN !== 1'b1; i++)
         @(posedge clk);
      #1 chk({31'h0, readyN}, 32'h1, "ready not released");
   endtask
   task automatic read_result(input logic [14:0] c, input logic flt);
      rtdr_host_model_i.select();
      rdr(A_RES);
      chk(rd, {16'h0, c, flt}, "result word");
      rtdr_host_model_i.deselect();
      wait_ready_high();
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rdr(A_THH);
      chk(rd, 32'hFFFF, "high threshold reset");
      rdr(A_THL);
      chk(rd, 32'h0, "low threshold reset");
      rdr(8'hFC);
      chk(rd, 32'hFF, "unmapped read");
      chk({31'h0, readyN}, 32'h1, "ready idle");
   endtask
   task automatic t_result();
      conv(15'h4000);
      chk({31'h0, readyN}, 32'h0, "ready after result");
      read_result(15'h4000, 1'b0);
      conv(15'h1234);
      rtdr_host_model_i.select();
      rtdr_host_model_i.deselect();
      repeat (8) @(posedge clk);
      chk({31'h0, readyN}, 32'h0, "frame without read");
      conv(15'h2345);
      conv(15'h3456);
      chk({31'h0, readyN}, 32'h0, "ready held by newer");
      read_result(15'h3456, 1'b0);
   endtask
   task automatic t_thresh();
      wr(A_THL, 32'h0200);
      wr(A_THH, 32'h2000);
      conv(15'h0FFF);
      rdr(A_FLT);
      chk(rd, 32'h0, "below high threshold");
      conv(15'h1000);
      rdr(A_FLT);
      chk(rd, F_HI, "high threshold equal");
      conv(15'h0100);
      rdr(A_FLT);
      chk(rd, F_HI | F_LO, "low threshold equal");
      conv(15'h0500);
      rdr(A_FLT);
      chk(rd, F_HI | F_LO, "flags latched");
      read_result(15'h0500, 1'b1);
      wr(A_CTL, 32'h2);
      rdr(A_FLT);
      chk(rd, 32'h0, "fault clear");
      wr(A_THH, 32'hFFFF);
      conv(15'h7FFF);
      rdr(A_FLT);
      chk(rd, F_HI, "full scale open element");
      wr(A_CTL, 32'h2);
   endtask
   task automatic t_volt();
      refNegAbovePin <= 1'b1;
      wr(A_CTL, 32'h1);
      rd = 32'h1;
      for (int i = 0; i < 40 && rd[0] !== 1'b0; i++)
         rdr(A_CTL);
      chk(rd & 32'h1, 32'h0, "detection finishes");
      refNegAbovePin <= 1'b0;
      rdr(A_FLT);
      chk(rd, F_REF, "open detect on demand");
      overUnderPin <= 1'b1;
      repeat (4) @(posedge clk);
      overUnderPin <= 1'b0;
      repeat (4) @(posedge clk);
      rdr(A_FLT);
      chk(rd, F_REF | F_OV, "supply fault bit");
      wr(A_CTL, 32'h2);
      // second detection with both low-side comparators tripped
      refNegBelowPin <= 1'b1;
      sensorNegBelowPin <= 1'b1;
      wr(A_CTL, 32'h1);
      rd = 32'h1;
      for (int i = 0; i < 40 && rd[0] !== 1'b0; i++)
         rdr(A_CTL);
      chk(rd & 32'h1, 32'h0, "second detection finishes");
      refNegBelowPin <= 1'b0;
      sensorNegBelowPin <= 1'b0;
      rdr(A_FLT);
      chk(rd, 32'h18, "low comparator bits");
      wr(A_CTL, 32'h2);
   endtask
   // interrupt raised, masked, unmasked, then cleared by writing one
   task automatic t_irq();
      rdr(A_IST);
      chk(rd, 32'h7, "irq status sources");
      wr(A_IST, 32'h7);
      wr(A_IMK, 32'h1);
      conv(15'h3000);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1, "irq on result");
      rdr(A_IST);
      chk(rd, 32'h1, "irq status");
      wr(A_IMK, 32'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0, "irq masked");
      wr(A_IMK, 32'h1);
      wr(A_IST, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0, "irq cleared");
      read_result(15'h3000, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {reset, convValid, regWr, regRd, refNegAbovePin, overUnderPin} = 6'b100000;
      convCode = 15'h0;
      refNegBelowPin = 1'b0;
      sensorNegBelowPin = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_result();
      t_thresh();
      t_volt();
      t_irq();
      conclude();
   end
endmodule
